// ---- src/cgsr_defs.svh ----
// Offsets, field positions, reset values and counts of the serial slave
`ifndef CGSR_DEFS_SVH
`define CGSR_DEFS_SVH

`define CGSR_SLAVE_ADDR      7'h69
`define CGSR_CMD_BYTE_BIT    7
`define CGSR_OFS_DIFF_EN     7'h00
`define CGSR_OFS_MISC_EN     7'h01
`define CGSR_OFS_BUS_EN      7'h02
`define CGSR_OFS_STOP_SEL    7'h03
`define CGSR_RST_DIFF_EN     8'hFF
`define CGSR_RST_MISC_EN     8'hF6
`define CGSR_RST_BUS_EN      8'hFF
`define CGSR_RST_STOP_SEL    8'h00
`define CGSR_BLOCK_COUNT     8'h04
`define CGSR_R1_FREE0_BIT    7
`define CGSR_R1_DOT_BIT      6
`define CGSR_R1_CLK48_BIT    5
`define CGSR_R1_REF_BIT      4
`define CGSR_R1_SPREAD_BIT   0
`define CGSR_BITS_PER_BYTE   4'h8
`define CGSR_LAST_TX_BIT     4'h7

`endif

// ---- src/cgsr_pkg.sv ----
// Types shared by the serial slave and its register file
package cgsr_pkg;

    typedef enum logic [2:0] {
        ST_IDLE      = 3'b000,
        ST_ADDR      = 3'b001,
        ST_RX        = 3'b010,
        ST_RX_ACK    = 3'b011,
        ST_TX        = 3'b100,
        ST_TX_ACK    = 3'b101,
        ST_WAIT_STOP = 3'b110
    } cgsr_state_t;

    typedef enum logic [1:0] {
        PH_CMD   = 2'b00,
        PH_COUNT = 2'b01,
        PH_DATA  = 2'b10
    } cgsr_phase_t;

    typedef struct packed {
        cgsr_state_t st;
        cgsr_phase_t ph;
        logic [3:0]  cnt;
        logic [7:0]  shf;
        logic [7:0]  tx;
        logic        rw;
        logic        byte_mode;
        logic [6:0]  ptr;
        logic        sda_oe;
        logic        sda_o;
        logic        scl_d;
        logic        sda_d;
        logic        wr;
        logic [6:0]  waddr;
        logic [7:0]  wdat;
        logic [7:1]  diff_en;
        logic        dot_en;
        logic        clk48_en;
        logic        ref_en;
        logic [2:0]  frb_en;
        logic [5:0]  bus_en;
        logic [1:0]  cpu_en;
        logic        spread;
    } cgsr_main_t;

    typedef struct packed {
        logic [3:0][7:0] regs;
        logic [7:0]      rd;
    } cgsr_rf_t;

endpackage

// ---- src/cgsr_sync.sv ----
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module cgsr_sync #(
    parameter int               WIDTH     = 4,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             clk_sys_in,
    input  wire logic             sys_rst_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } cgsr_sync_t;

    cgsr_sync_t r_ff;
    cgsr_sync_t nxt_r;

    always_comb begin
        nxt_r.meta   = async_in;
        nxt_r.stable = r_ff.meta;
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            r_ff <= {RESET_VAL, RESET_VAL};
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign sync_out = r_ff.stable;
endmodule

// ---- src/cgsr_regfile.sv ----
// Four control bytes with registered read port
`timescale 1ns/1ps
`include "cgsr_defs.svh"
module cgsr_regfile #(
    parameter int NUM_REGS = 4
) (
    input  wire logic       clk_sys_in,
    input  wire logic       sys_rst_in,
    input  wire logic       wr_en_in,
    input  wire logic [6:0] wr_addr_in,
    input  wire logic [7:0] wr_data_in,
    input  wire logic [6:0] rd_addr_in,
    output logic      [7:0] rd_data_out,
    output logic      [7:0] ctl0_out,
    output logic      [7:0] ctl1_out,
    output logic      [7:0] ctl2_out,
    output logic      [7:0] ctl3_out
);
    import cgsr_pkg::*;

    cgsr_rf_t r_ff;
    cgsr_rf_t nxt_r;

    always_comb begin
        nxt_r = r_ff;
        // Offsets past the last byte read as zero and drop writes
        nxt_r.rd = 8'h00;
        for (int i = 0; i < NUM_REGS; i++) begin
            if (wr_en_in && wr_addr_in == 7'(i)) begin
                nxt_r.regs[i] = wr_data_in;
            end
            if (rd_addr_in == 7'(i)) begin
                nxt_r.rd = r_ff.regs[i];
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            r_ff.regs <= {`CGSR_RST_STOP_SEL, `CGSR_RST_BUS_EN,
                          `CGSR_RST_MISC_EN, `CGSR_RST_DIFF_EN};
            r_ff.rd   <= 8'h00;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign rd_data_out = r_ff.rd;
    assign ctl0_out    = r_ff.regs[0];
    assign ctl1_out    = r_ff.regs[1];
    assign ctl2_out    = r_ff.regs[2];
    assign ctl3_out    = r_ff.regs[3];
endmodule

// ---- src/cgsr_top.sv ----
// Serial slave port and control bytes 0..3 of the clock generator
`timescale 1ns/1ps
`include "cgsr_defs.svh"
module cgsr_top (
    input  wire logic       clk_sys_in,
    input  wire logic       sys_rst_in,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_out,
    input  wire logic       i2c_compat_en_in,
    input  wire logic       sw_stop_request_in,
    output logic      [7:1] diff_ref_pair_en_out,
    output logic            dot_clock_pair_en_out,
    output logic            clk48_out_0_en_out,
    output logic            reference_out_0_en_out,
    output logic      [2:0] free_run_bus_clk_en_out,
    output logic      [5:0] bus_clk_out_en_out,
    output logic      [1:0] cpu_pair_en_out,
    output logic            processor_pll_spread_out
);
    import cgsr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [3:0] pins_s;
    logic       scl_s;
    logic       sda_s;
    logic       compat_s;
    logic       stop_s;
    logic [7:0] rd_data;
    logic [7:0] ctl0;
    logic [7:0] ctl1;
    logic [7:0] ctl2;
    logic [7:0] ctl3;

    cgsr_main_t r_ff;
    cgsr_main_t nxt_r;

    // Bus lines idle high, so they leave reset high to avoid a false start
    cgsr_sync #(
        .WIDTH     (4),
        .RESET_VAL (4'b0011)
    ) u_sync (
        .clk_sys_in (clk_sys_in),
        .sys_rst_in (sys_rst_in),
        .async_in   ({sw_stop_request_in, i2c_compat_en_in, sda_in, scl_in}),
        .sync_out   (pins_s)
    );

    assign scl_s    = pins_s[0];
    assign sda_s    = pins_s[1];
    assign compat_s = pins_s[2];
    assign stop_s   = pins_s[3];

    cgsr_regfile #(
        .NUM_REGS (4)
    ) u_regs (
        .clk_sys_in  (clk_sys_in),
        .sys_rst_in  (sys_rst_in),
        .wr_en_in    (r_ff.wr),
        .wr_addr_in  (r_ff.waddr),
        .wr_data_in  (r_ff.wdat),
        .rd_addr_in  (r_ff.ptr),
        .rd_data_out (rd_data),
        .ctl0_out    (ctl0),
        .ctl1_out    (ctl1),
        .ctl2_out    (ctl2),
        .ctl3_out    (ctl3)
    );

    ////////////////////////////////////////////////////////////////////////
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    assign scl_rise  = scl_s && !r_ff.scl_d;
    assign scl_fall  = !scl_s && r_ff.scl_d;
    assign bus_start = scl_s && r_ff.scl_d && r_ff.sda_d && !sda_s;
    assign bus_stop  = scl_s && r_ff.scl_d && !r_ff.sda_d && sda_s;

    always_comb begin
        nxt_r       = r_ff;
        nxt_r.scl_d = scl_s;
        nxt_r.sda_d = sda_s;
        nxt_r.wr    = 1'b0;
        nxt_r.sda_o = 1'b0;

        // Gating is applied in the system clock so a stop takes effect
        // on a whole cycle boundary and never chops a pulse
        nxt_r.diff_en  = ctl0[7:1] & ~(ctl3[7:1] & {7{stop_s}});
        nxt_r.dot_en   = ctl1[`CGSR_R1_DOT_BIT];
        nxt_r.clk48_en = ctl1[`CGSR_R1_CLK48_BIT];
        nxt_r.ref_en   = ctl1[`CGSR_R1_REF_BIT];
        nxt_r.frb_en   = {ctl2[1:0], ctl1[`CGSR_R1_FREE0_BIT]};
        nxt_r.bus_en   = ctl2[7:2];
        nxt_r.cpu_en   = ctl1[2:1];
        nxt_r.spread   = ctl1[`CGSR_R1_SPREAD_BIT];

        if (bus_start) begin
            nxt_r.st     = ST_ADDR;
            nxt_r.cnt    = 4'h0;
            nxt_r.sda_oe = 1'b0;
        end else if (bus_stop) begin
            nxt_r.st     = ST_IDLE;
            nxt_r.sda_oe = 1'b0;
        end else begin
            case (r_ff.st)
                ST_ADDR, ST_RX: begin
                    if (scl_rise && r_ff.cnt != `CGSR_BITS_PER_BYTE) begin
                        nxt_r.shf = {r_ff.shf[6:0], sda_s};
                        nxt_r.cnt = r_ff.cnt + 4'h1;
                    end
                    if (scl_fall && r_ff.cnt == `CGSR_BITS_PER_BYTE) begin
                        if (r_ff.st == ST_ADDR) begin
                            if (r_ff.shf[7:1] == `CGSR_SLAVE_ADDR) begin
                                nxt_r.sda_oe = 1'b1;
                                nxt_r.rw     = r_ff.shf[0];
                                nxt_r.ph     = PH_CMD;
                                nxt_r.st     = ST_RX_ACK;
                            end else begin
                                // Someone else's frame: stay silent
                                nxt_r.st = ST_IDLE;
                            end
                        end else begin
                            nxt_r.sda_oe = 1'b1;
                            nxt_r.st     = ST_RX_ACK;
                            case (r_ff.ph)
                                PH_CMD: begin
                                    nxt_r.byte_mode =
                                        r_ff.shf[`CGSR_CMD_BYTE_BIT];
                                    nxt_r.ptr = r_ff.shf[7] ?
                                        r_ff.shf[6:0] : 7'h00;
                                    nxt_r.ph = (!r_ff.shf[7] && !compat_s) ?
                                        PH_COUNT : PH_DATA;
                                end
                                PH_COUNT: begin
                                    // Count is taken for protocol only;
                                    // the stop ends the write
                                    nxt_r.ph = PH_DATA;
                                end
                                PH_DATA: begin
                                    nxt_r.wr    = 1'b1;
                                    nxt_r.waddr = r_ff.ptr;
                                    nxt_r.wdat  = r_ff.shf;
                                    nxt_r.ptr   = r_ff.ptr + 7'h01;
                                end
                                default: begin
                                    nxt_r.ph = PH_CMD;
                                end
                            endcase
                        end
                    end
                end
                ST_RX_ACK: begin
                    if (scl_fall) begin
                        nxt_r.cnt = 4'h0;
                        if (r_ff.rw) begin
                            nxt_r.st = ST_TX;
                            if (r_ff.byte_mode) begin
                                nxt_r.tx     = rd_data;
                                nxt_r.sda_oe = !rd_data[7];
                                nxt_r.ptr    = r_ff.ptr + 7'h01;
                            end else begin
                                nxt_r.tx     = `CGSR_BLOCK_COUNT;
                                nxt_r.sda_oe = ~|(`CGSR_BLOCK_COUNT & 8'h80);
                            end
                        end else begin
                            nxt_r.sda_oe = 1'b0;
                            nxt_r.st     = ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (r_ff.cnt == `CGSR_LAST_TX_BIT) begin
                            nxt_r.sda_oe = 1'b0;
                            nxt_r.st     = ST_TX_ACK;
                        end else begin
                            nxt_r.tx     = {r_ff.tx[6:0], 1'b0};
                            nxt_r.sda_oe = !r_ff.tx[6];
                            nxt_r.cnt    = r_ff.cnt + 4'h1;
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rise && sda_s) begin
                        // Not acknowledged: the master is done
                        nxt_r.st = ST_WAIT_STOP;
                    end else if (scl_fall) begin
                        nxt_r.tx     = rd_data;
                        nxt_r.sda_oe = !rd_data[7];
                        nxt_r.ptr    = r_ff.ptr + 7'h01;
                        nxt_r.cnt    = 4'h0;
                        nxt_r.st     = ST_TX;
                    end
                end
                ST_IDLE, ST_WAIT_STOP: begin
                    nxt_r.sda_oe = 1'b0;
                end
                default: begin
                    nxt_r.st     = ST_IDLE;
                    nxt_r.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            r_ff          <= '0;
            r_ff.st       <= ST_IDLE;
            r_ff.ph       <= PH_CMD;
            r_ff.scl_d    <= 1'b1;
            r_ff.sda_d    <= 1'b1;
            r_ff.diff_en  <= 7'(`CGSR_RST_DIFF_EN >> 1);
            r_ff.dot_en   <= 1'b1;
            r_ff.clk48_en <= 1'b1;
            r_ff.ref_en   <= 1'b1;
            r_ff.frb_en   <= 3'h7;
            r_ff.bus_en   <= 6'h3F;
            r_ff.cpu_en   <= 2'h3;
            r_ff.spread   <= 1'b0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign sda_out                  = r_ff.sda_o;
    assign sda_oe_out               = r_ff.sda_oe;
    assign diff_ref_pair_en_out     = r_ff.diff_en;
    assign dot_clock_pair_en_out    = r_ff.dot_en;
    assign clk48_out_0_en_out       = r_ff.clk48_en;
    assign reference_out_0_en_out   = r_ff.ref_en;
    assign free_run_bus_clk_en_out  = r_ff.frb_en;
    assign bus_clk_out_en_out       = r_ff.bus_en;
    assign cpu_pair_en_out          = r_ff.cpu_en;
    assign processor_pll_spread_out = r_ff.spread;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);

    property p_idle_silent;
        r_ff.st == ST_IDLE |-> !sda_oe_out;
    endproperty
    a_idle_silent: assert property (p_idle_silent)
        else $error("Data line driven while idle");

    property p_foreign_addr;
        (r_ff.st == ST_ADDR && scl_fall && !bus_start && !bus_stop &&
         r_ff.cnt == 4'h8 && r_ff.shf[7:1] != 7'h69)
        |=> !sda_oe_out ##1 !sda_oe_out && !r_ff.wr;
    endproperty
    a_foreign_addr: assert property (p_foreign_addr)
        else $error("Foreign address was acknowledged");

    property p_own_addr;
        (r_ff.st == ST_ADDR && scl_fall && !bus_start && !bus_stop &&
         r_ff.cnt == 4'h8 && r_ff.shf[7:1] == 7'h69)
        |=> sda_oe_out && !sda_out && r_ff.st == ST_RX_ACK;
    endproperty
    a_own_addr: assert property (p_own_addr)
        else $error("Own address not acknowledged");

    property p_block_offset;
        (r_ff.st == ST_RX && r_ff.ph == PH_CMD && scl_fall && !bus_start &&
         !bus_stop && r_ff.cnt == 4'h8 && !r_ff.shf[7])
        |=> r_ff.ptr == 7'h00 && !r_ff.byte_mode;
    endproperty
    a_block_offset: assert property (p_block_offset)
        else $error("Block command did not start at offset zero");

    property p_byte_offset;
        (r_ff.st == ST_RX && r_ff.ph == PH_CMD && scl_fall && !bus_start &&
         !bus_stop && r_ff.cnt == 4'h8 && r_ff.shf[7])
        |=> r_ff.ptr == $past(r_ff.shf[6:0]) && r_ff.byte_mode;
    endproperty
    a_byte_offset: assert property (p_byte_offset)
        else $error("Byte command offset not taken");

    property p_count_skip;
        (r_ff.st == ST_RX && r_ff.ph == PH_CMD && scl_fall && !bus_start &&
         !bus_stop && r_ff.cnt == 4'h8 && !r_ff.shf[7])
        |=> r_ff.ph == ($past(compat_s) ? PH_DATA : PH_COUNT);
    endproperty
    a_count_skip: assert property (p_count_skip)
        else $error("Count phase chosen wrongly");

    property p_block_count;
        (r_ff.st == ST_RX_ACK && scl_fall && r_ff.rw && !r_ff.byte_mode &&
         !bus_start && !bus_stop)
        |=> r_ff.tx == 8'h04 && r_ff.st == ST_TX ##1 r_ff.ptr == 7'h00;
    endproperty
    a_block_count: assert property (p_block_count)
        else $error("Block read did not open with the count");

    property p_write_lands;
        r_ff.wr && r_ff.waddr == 7'h01 |=> ##1
            processor_pll_spread_out == $past(r_ff.wdat[0], 2);
    endproperty
    a_write_lands: assert property (p_write_lands)
        else $error("Spread enable did not follow a write");

    property p_stop_gate;
        (stop_s && ctl3[7] && ctl0[7]) [*2] |=> !diff_ref_pair_en_out[7];
    endproperty
    a_stop_gate: assert property (p_stop_gate)
        else $error("Stoppable pair kept running under stop");

    property p_reset_defaults;
        $fell(sys_rst_in) |-> diff_ref_pair_en_out == 7'h7F &&
            !processor_pll_spread_out && cpu_pair_en_out == 2'h3 &&
            bus_clk_out_en_out == 6'h3F && !sda_oe_out;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults)
        else $error("Outputs not at defaults after reset");
endmodule

// ---- testbench/cgsr_host_model.sv ----
// Serial bus master model driving the clock and open-drain data line
`timescale 1ns/1ps
module cgsr_host_model (
    input  wire logic clk_sys_in,
    input  wire logic dev_sda_in,
    input  wire logic dev_sda_oe_in,
    output logic      scl_out,
    output logic      sda_wire_out
);
    logic host_low_ff;

    // Pull-up wins unless some party pulls low
    assign sda_wire_out = ~(host_low_ff | (dev_sda_oe_in & ~dev_sda_in));

    initial begin
        scl_out     = 1'b1;
        host_low_ff = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Low phase 5 clocks, high 3: data moves well clear of the rising edge
    task automatic put_bit(input logic b);
        tick(2);
        host_low_ff <= ~b;
        tick(3);
        scl_out <= 1'b1;
        tick(3);
        scl_out <= 1'b0;
    endtask

    task automatic get_bit(output logic b);
        tick(2);
        host_low_ff <= 1'b0;
        tick(3);
        scl_out <= 1'b1;
        tick(2);
        #1 b = sda_wire_out;
        tick(1);
        scl_out <= 1'b0;
    endtask

    // Extra waits so a late release by the device never looks like a stop
    task automatic start_cond();
        tick(2);
        host_low_ff <= 1'b0;
        tick(4);
        scl_out <= 1'b1;
        tick(4);
        host_low_ff <= 1'b1;
        tick(4);
        scl_out <= 1'b0;
    endtask

    task automatic stop_cond();
        tick(2);
        host_low_ff <= 1'b1;
        tick(4);
        scl_out <= 1'b1;
        tick(4);
        host_low_ff <= 1'b0;
        tick(6);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i]);
        end
        get_bit(b);
        ack = ~b;
    endtask

    // Acks every byte but the last, which gets a nack
    task automatic recv_byte(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            get_bit(d[i]);
        end
        put_bit(last);
    endtask
endmodule

// ---- testbench/test_clockgen_serial_ctrl_regs.sv ----
// Self-checking bench for the serial slave and its control bytes
`timescale 1ns/1ps
module test_clockgen_serial_ctrl_regs;
    logic       clk_sys_in;
    logic       sys_rst_in;
    logic       scl;
    logic       sda_wire;
    logic       sda_drv;
    logic       sda_oe;
    logic       compat_en;
    logic       stop_req;
    logic [7:1] diff_en;
    logic       dot_en;
    logic       c48_en;
    logic       ref_en;
    logic       spread;
    logic [2:0] frb_en;
    logic [5:0] bus_en;
    logic [1:0] cpu_en;
    logic [7:0] regs [4];
    logic       watch_oe;
    logic       oe_seen;
    int         errors;
    int         num_checks;

    cgsr_top cgsr_top_i (
        .clk_sys_in               (clk_sys_in),
        .sys_rst_in               (sys_rst_in),
        .scl_in                   (scl),
        .sda_in                   (sda_wire),
        .sda_out                  (sda_drv),
        .sda_oe_out               (sda_oe),
        .i2c_compat_en_in         (compat_en),
        .sw_stop_request_in       (stop_req),
        .diff_ref_pair_en_out     (diff_en),
        .dot_clock_pair_en_out    (dot_en),
        .clk48_out_0_en_out       (c48_en),
        .reference_out_0_en_out   (ref_en),
        .free_run_bus_clk_en_out  (frb_en),
        .bus_clk_out_en_out       (bus_en),
        .cpu_pair_en_out          (cpu_en),
        .processor_pll_spread_out (spread)
    );

    cgsr_host_model cgsr_host_model_i (
        .clk_sys_in    (clk_sys_in),
        .dev_sda_in    (sda_drv),
        .dev_sda_oe_in (sda_oe),
        .scl_out       (scl),
        .sda_wire_out  (sda_wire)
    );

    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    always @(posedge clk_sys_in) begin
        if (watch_oe && sda_oe === 1'b1) begin
            oe_seen <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("errors %0d checks %0d", errors, num_checks);
        if (errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, exp, input string what);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got,
                     exp);
        end
    endtask

    task automatic check_outs(input string what);
        logic [21:0] exp;
        exp = {regs[0][7:1] & ~(regs[3][7:1] & {7{stop_req}}),
               regs[1][6:4], regs[2][1:0], regs[1][7], regs[2][7:2],
               regs[1][2:0]};
        check({diff_en, dot_en, c48_en, ref_en, frb_en, bus_en, cpu_en,
               spread}, exp, what);
    endtask

    task automatic send_chk(input logic [7:0] d, input logic exp_ack);
        logic ack;
        cgsr_host_model_i.send_byte(d, ack);
        check(ack, exp_ack, "ack");
    endtask

    task automatic wr_frame(input logic [7:0] b[$]);
        cgsr_host_model_i.start_cond();
        send_chk(8'hD2, 1'b1);
        foreach (b[i]) send_chk(b[i], 1'b1);
        cgsr_host_model_i.stop_cond();
    endtask

    task automatic rd_frame(input logic [7:0] cmd, input logic [7:0] e[$]);
        logic [7:0] d;
        cgsr_host_model_i.start_cond();
        send_chk(8'hD2, 1'b1);
        send_chk(cmd, 1'b1);
        cgsr_host_model_i.start_cond();
        send_chk(8'hD3, 1'b1);
        foreach (e[i]) begin
            cgsr_host_model_i.recv_byte(i == e.size() - 1, d);
            check(d, e[i], "read byte");
        end
        cgsr_host_model_i.stop_cond();
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_byte();
        wr_frame('{8'h81, 8'h01});
        regs[1] = 8'h01;
        check_outs("byte write");
        rd_frame(8'h81, '{8'h01});
        rd_frame(8'h82, '{8'hFF});
    endtask

    task automatic t_block();
        wr_frame('{8'h00, 8'h04, 8'hA5, 8'h53, 8'h3C, 8'h00});
        regs = '{8'hA5, 8'h53, 8'h3C, 8'h00};
        check_outs("block write");
        rd_frame(8'h00, '{8'h04, 8'hA5, 8'h53, 8'h3C, 8'h00, 8'h00});
    endtask

    task automatic t_compat();
        compat_en <= 1'b1;
        wr_frame('{8'h00, 8'hFF, 8'hF6, 8'hFF, 8'h00});
        regs = '{8'hFF, 8'hF6, 8'hFF, 8'h00};
        check_outs("compat write");
        compat_en <= 1'b0;
    endtask

    // A foreign address must leave the line alone for the whole frame
    task automatic t_foreign();
        watch_oe <= 1'b1;
        cgsr_host_model_i.start_cond();
        send_chk(8'hD4, 1'b0);
        send_chk(8'h81, 1'b0);
        send_chk(8'h00, 1'b0);
        cgsr_host_model_i.stop_cond();
        watch_oe <= 1'b0;
        check(oe_seen, 1'b0, "foreign drive");
        check_outs("foreign write");
    endtask

    task automatic t_stop();
        wr_frame('{8'h83, 8'hAA});
        regs[3] = 8'hAA;
        check_outs("stop select");
        stop_req <= 1'b1;
        cgsr_host_model_i.tick(6);
        check_outs("stopped");
        stop_req <= 1'b0;
        cgsr_host_model_i.tick(6);
        check_outs("resumed");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_rst_in = 1'b1;
        compat_en  = 1'b0;
        stop_req   = 1'b0;
        watch_oe   = 1'b0;
        oe_seen    = 1'b0;
        errors     = 0;
        num_checks = 0;
        regs       = '{8'hFF, 8'hF6, 8'hFF, 8'h00};
        repeat (5) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        repeat (4) @(posedge clk_sys_in);
        check_outs("defaults");
        t_byte();
        t_block();
        t_compat();
        t_foreign();
        t_stop();
        complete_run();
    end

    // Whole run needs well under 10000 clocks
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        errors++;
        complete_run();
    end
endmodule
